// ===== design/abcr_host.sv
/*
  Host end: software engine that programs the register bank with the
  recommended pages and configuration and the requested burst rounded
  down to a multiple of four, then serves single register accesses.
  Assumes the device answers reads one cycle after the access.
*/
`timescale 1ns/1ps
`default_nettype none
module abcr_host
  import abcr_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  abcr_if.host             bus,
  input  wire logic        init_i,
  input  wire logic [4:0]  burst_req_i,
  input  wire logic        req_i,
  input  wire logic        req_wr_i,
  input  wire logic [11:0] req_addr_i,
  input  wire logic [7:0]  req_wdata_i,
  output logic             busy_o,
  output logic             rd_valid_o,
  output logic [7:0]       rd_data_o,
  output logic             double_buf_o,
  output logic [7:0]       lan_ring_first_page_o,
  output logic [7:0]       lan_ring_last_page_o,
  output logic [7:0]       transmit_page_o
);
  import abcr_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_STOP, ST_BURST, ST_CFG, ST_WAIT} abcr_hstate_t;

  typedef struct packed {
    abcr_hstate_t st;
    logic         sel;
    logic         wr;
    logic [11:0]  addr;
    logic [7:0]   wdata;
    logic         busy;
    logic         rd_valid;
    logic [7:0]   rd_data;
    logic         dbl;
    logic [7:0]   first_pg;
    logic [7:0]   last_pg;
    logic [7:0]   tx_pg;
    logic [7:0]   burst;
  } abcr_host_t;

  abcr_host_t state_reg;
  abcr_host_t state_next;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    state_next          = state_reg;
    state_next.sel      = 1'b0;
    state_next.wr       = 1'b0;
    state_next.rd_valid = bus.io_rvalid;
    if (bus.io_rvalid) begin
      state_next.rd_data = bus.io_rdata;
    end
    case (state_reg.st)
      ST_IDLE: begin
        state_next.busy = 1'b0;
        if (init_i) begin
          // Round the burst down to a multiple of four.
          state_next.burst    = {3'b000, burst_req_i[4:2], 2'b00}; // RULE_12 RULE_11
          state_next.first_pg = REC_RX_START; // RULE_02 RULE_03
          state_next.last_pg  = REC_RX_STOP; // RULE_05 RULE_06
          state_next.tx_pg    = REC_TX_PAGE; // RULE_09
          state_next.busy     = 1'b1;
          state_next.st       = ST_START;
        end else if (req_i) begin
          state_next.sel   = 1'b1;
          state_next.wr    = req_wr_i;
          state_next.addr  = req_addr_i;
          state_next.wdata = req_wdata_i;
          state_next.busy  = 1'b1;
          state_next.st    = ST_WAIT;
        end
      end
      ST_START: begin
        state_next.sel   = 1'b1;
        state_next.wr    = 1'b1;
        state_next.addr  = OFF_RX_START;
        state_next.wdata = state_reg.first_pg; // RULE_02
        state_next.st    = ST_STOP;
      end
      ST_STOP: begin
        state_next.sel   = 1'b1;
        state_next.wr    = 1'b1;
        state_next.addr  = OFF_RX_STOP;
        state_next.wdata = state_reg.last_pg; // RULE_05
        state_next.st    = ST_BURST;
      end
      ST_BURST: begin
        state_next.sel   = 1'b1;
        state_next.wr    = 1'b1;
        state_next.addr  = OFF_BURST;
        state_next.wdata = state_reg.burst;
        state_next.dbl   = (state_reg.burst >= DOUBLE_BUF_MIN); // RULE_13
        state_next.st    = ST_CFG;
      end
      ST_CFG: begin
        state_next.sel   = 1'b1;
        state_next.wr    = 1'b1;
        state_next.addr  = OFF_ARRAY_CFG;
        state_next.wdata = REC_CFG; // RULE_21
        state_next.st    = ST_WAIT;
      end
      ST_WAIT: begin
        // Busy drops together with the return to idle, where requests are taken.
        state_next.busy = 1'b0;
        state_next.st   = ST_IDLE;
      end
      default: state_next.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign bus.io_sel             = state_reg.sel;
  assign bus.io_wr              = state_reg.wr;
  assign bus.io_addr            = state_reg.addr;
  assign bus.io_wdata           = state_reg.wdata;
  assign busy_o                 = state_reg.busy;
  assign rd_valid_o             = state_reg.rd_valid;
  assign rd_data_o              = state_reg.rd_data;
  assign double_buf_o           = state_reg.dbl;
  assign lan_ring_first_page_o  = state_reg.first_pg;
  assign lan_ring_last_page_o   = state_reg.last_pg;
  assign transmit_page_o        = state_reg.tx_pg;
endmodule : abcr_host
`default_nettype wire

// ===== design/abcr_if.sv
/*
  Interface joining the register bank to its host software engine.
  Holds the byte-wide I/O register port; the testbench drives the clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface abcr_if (input wire logic ref_clk_i);
  logic        io_sel;
  logic        io_wr;
  logic [11:0] io_addr;
  logic [7:0]  io_wdata;
  logic [7:0]  io_rdata;
  logic        io_rvalid;
  logic        zero_wait;

  modport dev  (input io_sel, io_wr, io_addr, io_wdata, output io_rdata, io_rvalid, zero_wait);
  modport host (output io_sel, io_wr, io_addr, io_wdata, input io_rdata, io_rvalid, zero_wait);
endinterface : abcr_if
`default_nettype wire

// ===== design/abcr_pkg.sv
/*
  Package of the adapter buffer configuration register bank: register offsets,
  field positions, reset values and timing counts shared by both ends.
  Assumes a 125 MHz clock and byte-wide I/O register accesses.
*/
package abcr_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;

  localparam logic [11:0] OFF_RX_START   = 12'h400;
  localparam logic [11:0] OFF_RX_STOP    = 12'h401;
  localparam logic [11:0] OFF_BURST      = 12'h402;
  localparam logic [11:0] OFF_IO_SNAP    = 12'h403;
  localparam logic [11:0] OFF_MEM_SNAP   = 12'h404;
  localparam logic [11:0] OFF_ARRAY_CFG  = 12'h405;

  // Field positions of array_configuration.
  localparam int unsigned CFG_LAN_MASK   = 7;
  localparam int unsigned CFG_TC_MASK    = 6;
  localparam int unsigned CFG_ZERO_WAIT  = 5;
  localparam int unsigned CFG_TEST       = 4;
  localparam int unsigned CFG_RAM_MAP    = 3;
  localparam int unsigned CFG_BANK_HI    = 2;

  localparam logic [7:0] BURST_MASK      = 8'h1f;
  localparam logic [7:0] MEM_SNAP_MASK   = 8'hf0;
  localparam logic [7:0] CFG_RESET       = 8'h00;
  localparam logic [7:0] PAGE_RESET      = 8'h00;

  // Recommended software values.
  localparam logic [7:0] REC_RX_START    = 8'h26;
  localparam logic [7:0] REC_RX_STOP     = 8'h40;
  localparam logic [7:0] REC_TX_PAGE     = 8'h20;
  localparam logic [7:0] REC_CFG         = 8'h01;
  localparam logic [7:0] REC_BURST       = 8'h08;
  localparam logic [7:0] DOUBLE_BUF_MIN  = 8'h0c;

  // Local packet memory window.
  localparam logic [15:0] LOCAL_MEM_LO   = 16'h2000;
  localparam logic [15:0] LOCAL_MEM_HI   = 16'h3fff;

  // Test mode counting rate: 10 Mb/s gives one tick per 100 ns.
  localparam int unsigned CLK_PERIOD_PS  = 8000;
  localparam int unsigned TEST_BIT_PS    = 100000;
  localparam int unsigned TEST_DIV       = TEST_BIT_PS / CLK_PERIOD_PS;
  localparam int unsigned NORM_DIV       = 1;
endpackage : abcr_pkg

// ===== design/abcr_regs.sv
/*
  Device end: configuration register bank with receive ring pages, DMA burst
  count, jumper snapshots and the configuration register with its side effects.
  Assumes synchronous inputs, one I/O access per selected cycle, and jumper
  levels stable from power-up. Jumper changes after the first clock out of
  reset are not seen until the next reset.
*/
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// (RULE_01) Receive start page register, read/write, offset 400h.
// (RULE_02) Software matches start page to LAN controller.
// (RULE_03) Recommended start page value is 26h.
// (RULE_04) Receive stop page register, read/write, offset 401h.
// (RULE_05) Software matches stop page to LAN controller.
// (RULE_06) Recommended stop page value is 40h.
// (RULE_07) Receive writes stay within start..stop pages.
// (RULE_08) Local packet memory spans 2000h to 3FFFh.
// (RULE_09) Recommended transmit page 20h, receive from 2600h.
// (RULE_10) Burst count register at 402h, bits 4..0.
// (RULE_11) Burst time stays within 15 us refresh.
// (RULE_12) Burst count loaded only in multiples of four.
// (RULE_13) Burst count 12 or more needs double buffer.
// (RULE_14) I/O base snapshot at 403h, read-only, latched.
// (RULE_15) Memory base snapshot at 404h, low nibble zero.
// (RULE_16) Configuration bit 7 blocks LAN controller interrupts.
// (RULE_17) Terminal count raises DMA interrupt unless bit 6.
// (RULE_18) Bit 5 asserts zero wait on register I/O.
// (RULE_19) Bit 4 test mode counts at 10 Mb/s.
// (RULE_20) Bit 3 maps packet buffer into host memory.
// (RULE_21) Bits 2..0 select 8K segment when mapped.
// (RULE_22) Bank bits drive adapter address A15..A13.
// (RULE_23) Snapshot writes ignored; unused burst bits read zero.
module abcr_regs
  import abcr_pkg::*;
#(
  parameter int unsigned TICK_PERIOD_PS  = TEST_BIT_PS,
  parameter int unsigned CLOCK_PERIOD_PS = CLK_PERIOD_PS
)
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  abcr_if.dev              bus,
  input  wire logic [7:0]  io_jumper_i,
  input  wire logic [3:0]  memory_jumper_i,
  input  wire logic        lan_irq_i,
  input  wire logic        dma_active_i,
  input  wire logic        terminal_count_i,
  input  wire logic        dma_irq_clear_i,
  input  wire logic        host_mem_sel_i,
  input  wire logic [12:0] host_mem_addr_i,
  input  wire logic        rx_store_i,
  input  wire logic [7:0]  rx_store_page_i,
  output logic             host_lan_irq_o,
  output logic             dma_irq_o,
  output logic             mem_window_hit_o,
  output logic [15:0]      local_addr_o,
  output logic             rx_store_ok_o,
  output logic             count_tick_o,
  output logic [7:0]       rx_start_page_o,
  output logic [7:0]       rx_stop_page_o,
  output logic [4:0]       burst_count_o
);
  import abcr_pkg::*;

  // Width of the accumulator behind the fractional test-mode rate.
  localparam int unsigned ACC_W = $clog2(TICK_PERIOD_PS + CLOCK_PERIOD_PS + 1);

  ////////////////////////////////////////////////////////////////////////////

  // One register holds the whole state of the bank.
  typedef struct packed {
    logic [7:0]  rx_start;
    logic [7:0]  rx_stop;
    logic [7:0]  burst;
    logic [7:0]  io_snap;
    logic [7:0]  mem_snap;
    logic        snap_taken;
    logic [7:0]  cfg;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        zero_wait;
    logic        lan_irq;
    logic        dma_irq;
    logic        win_hit;
    logic [15:0] local_addr;
    logic        store_ok;
    logic [ACC_W-1:0] rate_acc;
    logic        tick;
  } abcr_state_t;

  abcr_state_t state_reg;
  abcr_state_t state_next;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic [ACC_W-1:0] acc_sum;
    state_next = state_reg;
    acc_sum    = state_reg.rate_acc + ACC_W'(CLOCK_PERIOD_PS);

    // Jumpers are caught once, on the first clock after reset release.
    if (!state_reg.snap_taken) begin
      state_next.io_snap    = io_jumper_i; // RULE_14
      state_next.mem_snap   = {memory_jumper_i, 4'h0} & MEM_SNAP_MASK; // RULE_15
      state_next.snap_taken = 1'b1;
    end

    // Answer strobes last for one cycle only.
    state_next.rvalid    = 1'b0;
    state_next.zero_wait = 1'b0;
    if (bus.io_sel) begin
      // Zero wait is offered only inside the gate array's own register page.
      if (bus.io_addr[11:4] == OFF_RX_START[11:4]) begin
        state_next.zero_wait = state_reg.cfg[CFG_ZERO_WAIT]; // RULE_18
      end
      if (bus.io_wr) begin
        // Snapshots and unknown offsets keep their contents on a write.
        case (bus.io_addr)
          OFF_RX_START:  state_next.rx_start = bus.io_wdata; // RULE_01
          OFF_RX_STOP:   state_next.rx_stop  = bus.io_wdata; // RULE_04
          OFF_BURST:     state_next.burst    = bus.io_wdata & BURST_MASK; // RULE_10 RULE_23
          OFF_ARRAY_CFG: state_next.cfg      = bus.io_wdata; // RULE_16 RULE_17 RULE_20 RULE_21
          OFF_IO_SNAP,
          OFF_MEM_SNAP:  state_next.rvalid   = 1'b0; // RULE_23
          default:       state_next.rvalid   = 1'b0;
        endcase
      end else begin
        // Read data is registered and stands for the one cycle of io_rvalid.
        state_next.rvalid = 1'b1;
        case (bus.io_addr)
          OFF_RX_START:  state_next.rdata = state_reg.rx_start;
          OFF_RX_STOP:   state_next.rdata = state_reg.rx_stop;
          OFF_BURST:     state_next.rdata = state_reg.burst & BURST_MASK; // RULE_23
          OFF_IO_SNAP:   state_next.rdata = state_reg.io_snap; // RULE_14
          OFF_MEM_SNAP:  state_next.rdata = state_reg.mem_snap & MEM_SNAP_MASK; // RULE_15
          OFF_ARRAY_CFG: state_next.rdata = state_reg.cfg;
          default:       state_next.rdata = 8'h00;
        endcase
      end
    end

    // The mask only gates the path to the host; the request is not stored.
    state_next.lan_irq = lan_irq_i & ~state_reg.cfg[CFG_LAN_MASK]; // RULE_16

    // Terminal count set wins over a clear in the same cycle.
    if (dma_irq_clear_i) begin
      state_next.dma_irq = 1'b0;
    end
    if (terminal_count_i && dma_active_i && !state_reg.cfg[CFG_TC_MASK]) begin
      state_next.dma_irq = 1'b1; // RULE_17
    end

    // Mapped window: bank bits form A15..A13 of the adapter address.
    state_next.win_hit    = host_mem_sel_i & state_reg.cfg[CFG_RAM_MAP]; // RULE_20 RULE_21
    state_next.local_addr = {state_reg.cfg[CFG_BANK_HI:0], host_mem_addr_i}; // RULE_22 RULE_08

    // A store is allowed only inside the ring and inside local packet memory.
    state_next.store_ok = rx_store_i
                          && (rx_store_page_i >= state_reg.rx_start)
                          && (rx_store_page_i < state_reg.rx_stop)
                          && (rx_store_page_i >= LOCAL_MEM_LO[15:8])
                          && (rx_store_page_i <= LOCAL_MEM_HI[15:8]); // RULE_07 RULE_08

    // Normal mode ticks every clock. Test mode adds the clock period to an
    // accumulator and ticks on each wrap, so the average tick period equals
    // the bit time even though it is not a whole number of clocks.
    state_next.tick = 1'b0;
    if (!state_reg.cfg[CFG_TEST]) begin
      state_next.rate_acc = '0;
      state_next.tick     = 1'b1;
    end else if (acc_sum >= ACC_W'(TICK_PERIOD_PS)) begin
      state_next.rate_acc = acc_sum - ACC_W'(TICK_PERIOD_PS);
      state_next.tick     = 1'b1; // RULE_19
    end else begin
      state_next.rate_acc = acc_sum;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      // Everything clears, so both interrupt masks come up passing.
      state_reg          <= '0;
      state_reg.rx_start <= PAGE_RESET;
      state_reg.rx_stop  <= PAGE_RESET;
      state_reg.cfg      <= CFG_RESET; // RULE_16 RULE_17
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Every output comes straight from the state register.
  assign bus.io_rdata      = state_reg.rdata;
  assign bus.io_rvalid     = state_reg.rvalid;
  assign bus.zero_wait     = state_reg.zero_wait;
  assign host_lan_irq_o    = state_reg.lan_irq;
  assign dma_irq_o         = state_reg.dma_irq;
  assign mem_window_hit_o  = state_reg.win_hit;
  assign local_addr_o      = state_reg.local_addr;
  assign rx_store_ok_o     = state_reg.store_ok;
  assign count_tick_o      = state_reg.tick;
  assign rx_start_page_o   = state_reg.rx_start;
  assign rx_stop_page_o    = state_reg.rx_stop;
  assign burst_count_o     = state_reg.burst[4:0];
endmodule : abcr_regs
`default_nettype wire

// ===== tb/abcr_asserts.sv
/*
  Checker of the byte-wide register port between host engine and register bank.
  Assumes it is instantiated beside the interface, on the bench clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none
module abcr_asserts (
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        io_sel,
  input wire logic        io_wr,
  input wire logic [11:0] io_addr,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_rvalid,
  input wire logic        zero_wait
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] sh_start, sh_stop, sh_burst, sh_cfg;
  logic       rd;
  assign rd = io_sel && !io_wr;
  ////////////////////////////////////////////////////////////////
  // Shadow copies of the writable registers, loaded on the same edge as the bank.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sh_start <= 8'h00;
      sh_stop  <= 8'h00;
      sh_burst <= 8'h00;
      sh_cfg   <= 8'h00;
    end else if (io_sel && io_wr) begin
      if (io_addr == 12'h400) sh_start <= io_wdata;
      if (io_addr == 12'h401) sh_stop <= io_wdata;
      if (io_addr == 12'h402) sh_burst <= io_wdata;
      if (io_addr == 12'h405) sh_cfg <= io_wdata;
    end
  end
  ////////////////////////////////////////////////////////////////
  chk_start_rdback: assert property (rd && io_addr == 12'h400 |=> io_rvalid && io_rdata == $past(sh_start))
    else $error("start page readback wrong");
  chk_stop_rdback: assert property (rd && io_addr == 12'h401 |=> io_rvalid && io_rdata == $past(sh_stop))
    else $error("stop page readback wrong");
  chk_burst_rdback: assert property (rd && io_addr == 12'h402 |=> io_rdata == ($past(sh_burst) & 8'h1f))
    else $error("burst count readback wrong");
  chk_cfg_rdback: assert property (rd && io_addr == 12'h405 |=> io_rdata == $past(sh_cfg))
    else $error("configuration readback wrong");
  chk_mem_snap_low: assert property (rd && io_addr == 12'h404 |=> io_rdata[3:0] == 4'h0)
    else $error("memory snapshot low nibble not zero");
  chk_read_answer: assert property (rd |=> io_rvalid)
    else $error("read not answered");
  chk_no_stray_valid: assert property (!rd |=> !io_rvalid)
    else $error("read valid without read");
  chk_zero_wait_on: assert property (rd && sh_cfg[5] && io_addr >= 12'h400 && io_addr <= 12'h405 |=> zero_wait)
    else $error("zero wait missing");
  chk_zero_wait_off: assert property (rd && !sh_cfg[5] |=> !zero_wait)
    else $error("zero wait while disabled");
  chk_zero_wait_idle: assert property (!io_sel |=> !zero_wait)
    else $error("zero wait without access");
  chk_zero_wait_page: assert property (io_sel && io_addr[11:4] != 8'h40 |=> !zero_wait)
    else $error("zero wait outside register page");
endmodule : abcr_asserts
`default_nettype wire

// ===== tb/abcr_tb.sv
/*
  Testbench joining host engine and register bank through the interface.
  Assumes the design files are compiled first; runs stand-alone.
*/
`timescale 1ns/1ps
`default_nettype none
module abcr_tb;
  import abcr_pkg::*;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, init_i = 1'b0, req_i = 1'b0, req_wr_i = 1'b0;
  logic lan_irq = 1'b0, dma_act = 1'b0, tc = 1'b0, irq_clr = 1'b0, mem_sel = 1'b0, store = 1'b0;
  logic [4:0] burst_req_i = 5'h00;
  logic [11:0] req_addr_i = 12'h000;
  logic [7:0] req_wdata_i = 8'h00, page = 8'h00;
  logic [12:0] mem_addr = 13'h0000;
  logic [7:0] io_jmp = 8'h40;
  logic [3:0] mem_jmp = 4'h2;
  logic busy, rd_valid, dbl, lan_irq_o, dma_irq, hit, store_ok, tick;
  logic [7:0] rd_data, first_pg, last_pg, tx_pg, start_pg, stop_pg;
  logic [4:0] burst;
  logic [15:0] laddr;
  int err_total = 0, total_checks = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  abcr_if i_abcr_if (.ref_clk_i(ref_clk_i));
  abcr_regs i_abcr_regs (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus(i_abcr_if.dev), .io_jumper_i(io_jmp),
    .memory_jumper_i(mem_jmp), .lan_irq_i(lan_irq), .dma_active_i(dma_act), .terminal_count_i(tc),
    .dma_irq_clear_i(irq_clr), .host_mem_sel_i(mem_sel), .host_mem_addr_i(mem_addr), .rx_store_i(store),
    .rx_store_page_i(page), .host_lan_irq_o(lan_irq_o), .dma_irq_o(dma_irq), .mem_window_hit_o(hit),
    .local_addr_o(laddr), .rx_store_ok_o(store_ok), .count_tick_o(tick), .rx_start_page_o(start_pg),
    .rx_stop_page_o(stop_pg), .burst_count_o(burst));
  abcr_host i_abcr_host (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus(i_abcr_if.host), .init_i(init_i),
    .burst_req_i(burst_req_i), .req_i(req_i), .req_wr_i(req_wr_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .busy_o(busy), .rd_valid_o(rd_valid), .rd_data_o(rd_data), .double_buf_o(dbl),
    .lan_ring_first_page_o(first_pg), .lan_ring_last_page_o(last_pg), .transmit_page_o(tx_pg));
  abcr_asserts i_abcr_asserts (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .io_sel(i_abcr_if.io_sel),
    .io_wr(i_abcr_if.io_wr), .io_addr(i_abcr_if.io_addr), .io_wdata(i_abcr_if.io_wdata),
    .io_rdata(i_abcr_if.io_rdata), .io_rvalid(i_abcr_if.io_rvalid), .zero_wait(i_abcr_if.zero_wait));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // One host access: waits for the engine to be idle, then, on a read only, waits for read data.
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    q = 8'h00;
    @(negedge ref_clk_i);
    while (busy !== 1'b0 && n < 40) begin
      @(negedge ref_clk_i);
      n++;
    end
    @(posedge ref_clk_i);
    req_i <= 1'b1;
    req_wr_i <= w;
    req_addr_i <= a;
    req_wdata_i <= d;
    @(posedge ref_clk_i);
    req_i <= 1'b0;
    if (!w) begin
      n = 0;
      while (rd_valid !== 1'b1 && n < 20) begin
        @(negedge ref_clk_i);
        n++;
      end
      chk(rd_valid, 1'b1);
      q = rd_data;
      @(posedge ref_clk_i);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] q;
    acc(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask
  task automatic wcfg(input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, OFF_ARRAY_CFG, d, q);
    rdc(OFF_ARRAY_CFG, d);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_init;
    rdc(OFF_ARRAY_CFG, 8'h00);
    @(posedge ref_clk_i);
    init_i <= 1'b1;
    burst_req_i <= 5'd14;
    @(posedge ref_clk_i);
    init_i <= 1'b0;
    rdc(OFF_BURST, 8'h0c);
    rdc(OFF_ARRAY_CFG, 8'h01);
    chk(first_pg, 8'h26);
    chk(last_pg, 8'h40);
    chk(tx_pg, 8'h20);
    chk(start_pg, 8'h26);
    chk(stop_pg, 8'h40);
    chk(dbl, 1'b1);
    chk(burst, 5'h0c);
  endtask
  task automatic t_regs;
    logic [7:0] q;
    io_jmp <= 8'h01;
    mem_jmp <= 4'h8;
    acc(1'b1, OFF_RX_START, 8'ha5, q);
    acc(1'b1, OFF_RX_STOP, 8'h5a, q);
    acc(1'b1, OFF_BURST, 8'hfc, q);
    acc(1'b1, OFF_IO_SNAP, 8'h00, q);
    acc(1'b1, OFF_MEM_SNAP, 8'hff, q);
    rdc(OFF_RX_START, 8'ha5);
    rdc(OFF_RX_STOP, 8'h5a);
    rdc(OFF_BURST, 8'h1c);
    rdc(OFF_IO_SNAP, 8'h40);
    rdc(OFF_MEM_SNAP, 8'h20);
    rdc(12'h406, 8'h00);
  endtask
  task automatic t_irq;
    wcfg(8'h00);
    @(posedge ref_clk_i);
    lan_irq <= 1'b1;
    dma_act <= 1'b1;
    tc <= 1'b1;
    @(posedge ref_clk_i);
    tc <= 1'b0;
    repeat (2) @(negedge ref_clk_i);
    chk(lan_irq_o, 1'b1);
    chk(dma_irq, 1'b1);
    wcfg(8'hc0);
    @(posedge ref_clk_i);
    irq_clr <= 1'b1;
    @(posedge ref_clk_i);
    irq_clr <= 1'b0;
    tc <= 1'b1;
    @(posedge ref_clk_i);
    tc <= 1'b0;
    repeat (2) @(negedge ref_clk_i);
    chk(lan_irq_o, 1'b0);
    chk(dma_irq, 1'b0);
  endtask
  task automatic t_map;
    wcfg(8'h29);
    rdc(12'h010, 8'h00);
    @(posedge ref_clk_i);
    mem_sel <= 1'b1;
    mem_addr <= 13'h0abc;
    repeat (2) @(negedge ref_clk_i);
    chk(hit, 1'b1);
    chk(laddr, 16'h2abc);
    wcfg(8'h0b);
    chk(laddr, 16'h6abc);
    wcfg(8'h01);
    repeat (2) @(negedge ref_clk_i);
    chk(hit, 1'b0);
  endtask
  task automatic t_store;
    logic [7:0] q;
    logic [7:0] pg [4] = '{8'h26, 8'h3f, 8'h40, 8'h25};
    logic ok [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    acc(1'b1, OFF_RX_START, 8'h26, q);
    acc(1'b1, OFF_RX_STOP, 8'h40, q);
    rdc(OFF_RX_STOP, 8'h40);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk_i);
      store <= 1'b1;
      page <= pg[i];
      repeat (2) @(negedge ref_clk_i);
      chk(store_ok, ok[i]);
    end
  endtask
  task automatic t_tick(input logic [7:0] cfg, input int span, input int exp);
    int cnt;
    cnt = 0;
    wcfg(cfg);
    repeat (span) begin
      @(negedge ref_clk_i);
      if (tick === 1'b1) cnt++;
    end
    chk(16'(cnt), 16'(exp));
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    t_init;
    t_regs;
    t_irq;
    t_map;
    t_store;
    t_tick(8'h10, 10 * TEST_BIT_PS / CLK_PERIOD_PS, 10);
    t_tick(8'h00, 24, 24);
    stop_test;
  end
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    err_total++;
    stop_test;
  end
endmodule : abcr_tb
`default_nettype wire
